// ==== core/iar_pkg.sv ====
package iar_pkg;

  localparam int unsigned IAR_NUM_EN_REGS = 5;
  localparam int unsigned IAR_EN_WIDTH    = 16;
  localparam int unsigned IAR_NUM_SRC     = IAR_NUM_EN_REGS * IAR_EN_WIDTH;
  localparam int unsigned IAR_ADDR_W      = 20;
  localparam int unsigned IAR_DATA_W      = 16;
  localparam int unsigned IAR_SEL_W       = 7;
  localparam int unsigned IAR_NUM_CH      = 4;

  localparam logic [IAR_ADDR_W-1:0] IAR_EN_BASE_ADDR   = 20'hfff20;
  localparam logic [IAR_ADDR_W-1:0] IAR_REG_STEP       = 20'h00002;
  localparam logic [IAR_ADDR_W-1:0] IAR_CH_SEL_BASE    = 20'hfff80;
  localparam logic [IAR_ADDR_W-1:0] IAR_CH_MODE_BASE   = 20'hfff90;

  localparam int unsigned IAR_MODE_CLAIM_BIT = 0;
  localparam int unsigned IAR_MODE_TE_BIT    = 1;
  localparam int unsigned IAR_MODE_TF0_BIT   = 2;
  localparam int unsigned IAR_MODE_TF1_BIT   = 3;
  localparam int unsigned IAR_MODE_W         = 4;

  typedef enum logic [1:0] {
    IAR_IDLE = 2'b00,
    IAR_BUSY = 2'b01
  } iar_state_e;

endpackage : iar_pkg

// ==== core/iar_src_sel.sv ====
`timescale 1ns/10ps
module iar_src_sel #(
  parameter int unsigned N = 80,
  parameter int unsigned W = 7
) (
  input  wire logic [N-1:0] i_src,
  input  wire logic [W-1:0] i_sel,
  output logic              o_hit
);

  // Out-of-range selections pick nothing rather than aliasing a real source.
  always_comb begin
    if (32'(i_sel) < N) begin
      o_hit = i_src[i_sel];
    end else begin
      o_hit = 1'b0;
    end
  end

endmodule : iar_src_sel

// ==== core/iar_router.sv ====
`timescale 1ns/10ps
module iar_router
  import iar_pkg::*;
#(
  parameter int unsigned               NCH       = IAR_NUM_CH,
  parameter logic [IAR_NUM_SRC-1:0]    SRC_VALID = {IAR_NUM_SRC{1'b1}}
) (
  input  wire logic                    I_CLK,
  input  wire logic                    I_RST_B,
  input  wire logic [IAR_ADDR_W-1:0]   I_ADDR,
  input  wire logic [IAR_DATA_W-1:0]   I_WDATA,
  input  wire logic                    I_WR,
  input  wire logic                    I_RD,
  output logic      [IAR_DATA_W-1:0]   O_RDATA,
  input  wire logic [IAR_NUM_SRC-1:0]  I_SRC_REQ,
  input  wire logic [NCH-1:0]          I_DMA_DONE,
  output logic      [NCH-1:0]          O_DMA_ACT,
  input  wire logic                    I_XC_DONE,
  input  wire logic                    I_XC_SOURCE_CLEAR_DISABLE_SELECT,
  output logic                         O_XC_ACT_REQ,
  output logic      [IAR_SEL_W-1:0]    O_XC_VECTOR,
  output logic      [IAR_NUM_SRC-1:0]  O_CPU_IRQ,
  output logic      [IAR_NUM_SRC-1:0]  O_SRC_CLR
);

  typedef struct packed {
    logic [IAR_NUM_EN_REGS-1:0][IAR_EN_WIDTH-1:0] en;
    logic [NCH-1:0][IAR_SEL_W-1:0]                sel;
    logic [NCH-1:0][IAR_MODE_W-1:0]               mode;
    iar_state_e                                   state;
    logic [IAR_SEL_W-1:0]                         vector;
    logic [IAR_NUM_SRC-1:0]                       cpu_hand;
    logic [IAR_NUM_SRC-1:0]                       cpu_irq;
    logic [IAR_NUM_SRC-1:0]                       clr;
    logic [NCH-1:0]                               dma_act;
    logic [IAR_DATA_W-1:0]                        rdata;
  } iar_st_s;

  iar_st_s st_ff;
  iar_st_s nxt_st;

  logic [NCH-1:0]         sel_hit;
  logic [NCH-1:0]         ch_active;
  logic [IAR_NUM_SRC-1:0] claim_vec;
  logic [IAR_NUM_SRC-1:0] en_flat;
  logic [IAR_NUM_SRC-1:0] xc_pend;

  function automatic logic mode_claims(input logic [IAR_MODE_W-1:0] m);
    return m[IAR_MODE_TF1_BIT] & ~m[IAR_MODE_TF0_BIT] & m[IAR_MODE_TE_BIT]
           & m[IAR_MODE_CLAIM_BIT];
  endfunction : mode_claims

  // The scan runs downward so that the last hit, the lowest index, wins.
  function automatic logic [IAR_SEL_W-1:0] first_set(input logic [IAR_NUM_SRC-1:0] v);
    logic [IAR_SEL_W-1:0] idx;
    idx = '0;
    for (int i = IAR_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IAR_SEL_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  function automatic logic [IAR_ADDR_W-1:0] reg_addr(input logic [IAR_ADDR_W-1:0] base,
                                                     input int unsigned k);
    return base + IAR_ADDR_W'(k) * IAR_REG_STEP;
  endfunction : reg_addr

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    iar_src_sel #(
      .N (IAR_NUM_SRC),
      .W (IAR_SEL_W)
    ) u_sel (
      .i_src (I_SRC_REQ),
      .i_sel (st_ff.sel[c]),
      .o_hit (sel_hit[c])
    );
  end

  always_comb begin
    claim_vec = '0;
    for (int c = 0; c < NCH; c++) begin
      ch_active[c] = mode_claims(st_ff.mode[c]);
      if (ch_active[c] && (32'(st_ff.sel[c]) < IAR_NUM_SRC)) begin
        claim_vec[st_ff.sel[c]] = 1'b1;
      end
    end
    en_flat = st_ff.en;
    // The peripheral drops its flag only after it sees the clear pulse, so a source
    // whose clear is still on its way must not be taken a second time.
    xc_pend = I_SRC_REQ & ~claim_vec & en_flat & ~st_ff.cpu_hand & ~st_ff.clr;
  end

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = '0;
    nxt_st.clr   = '0;
    // Register file; five enable registers only, nothing decodes above E.
    for (int k = 0; k < IAR_NUM_EN_REGS; k++) begin
      if (I_WR && I_ADDR == reg_addr(IAR_EN_BASE_ADDR, k)) begin
        nxt_st.en[k] = I_WDATA & SRC_VALID[k*IAR_EN_WIDTH +: IAR_EN_WIDTH];
      end
      if (I_RD && I_ADDR == reg_addr(IAR_EN_BASE_ADDR, k)) begin
        nxt_st.rdata = st_ff.en[k];
      end
    end
    for (int c = 0; c < NCH; c++) begin
      // Select and mode writes keep only their low bits; the rest are dropped.
      if (I_WR && I_ADDR == reg_addr(IAR_CH_SEL_BASE, c)) begin
        nxt_st.sel[c] = I_WDATA[IAR_SEL_W-1:0];
      end
      if (I_WR && I_ADDR == reg_addr(IAR_CH_MODE_BASE, c)) begin
        nxt_st.mode[c] = I_WDATA[IAR_MODE_W-1:0];
      end
      if (I_RD && I_ADDR == reg_addr(IAR_CH_SEL_BASE, c)) begin
        nxt_st.rdata = IAR_DATA_W'(st_ff.sel[c]);
      end
      if (I_RD && I_ADDR == reg_addr(IAR_CH_MODE_BASE, c)) begin
        nxt_st.rdata = IAR_DATA_W'(st_ff.mode[c]);
      end
      nxt_st.dma_act[c] = ch_active[c] & sel_hit[c];
      // The router clears a claimed source itself once its channel is served.
      if (I_DMA_DONE[c] && ch_active[c] && (32'(st_ff.sel[c]) < IAR_NUM_SRC)) begin
        nxt_st.clr[st_ff.sel[c]] = 1'b1;
      end
    end
    // A source handed to the CPU stays there until the peripheral drops it.
    nxt_st.cpu_hand = st_ff.cpu_hand & I_SRC_REQ;
    // Only one activation is outstanding; other sources wait until idle.
    case (st_ff.state)
      IAR_IDLE: begin
        if (|xc_pend) begin
          nxt_st.state  = IAR_BUSY;
          nxt_st.vector = first_set(xc_pend);
        end
      end
      IAR_BUSY: begin
        if (I_XC_DONE) begin
          nxt_st.state = IAR_IDLE;
          if (I_XC_SOURCE_CLEAR_DISABLE_SELECT) begin
            nxt_st.cpu_hand[st_ff.vector] = 1'b1;
          end else begin
            nxt_st.clr[st_ff.vector] = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.state = IAR_IDLE;
      end
    endcase
    nxt_st.cpu_irq = I_SRC_REQ & ~claim_vec & (~en_flat | st_ff.cpu_hand);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_RDATA      = st_ff.rdata;
  assign O_DMA_ACT    = st_ff.dma_act;
  assign O_XC_ACT_REQ = (st_ff.state == IAR_BUSY);
  assign O_XC_VECTOR  = st_ff.vector;
  assign O_CPU_IRQ    = st_ff.cpu_irq;
  assign O_SRC_CLR    = st_ff.clr;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // Every channel is watched, since software may claim through any of them.
  for (genvar c = 0; c < NCH; c++) begin : g_ch_chk
    dma_route_a: assert property (ch_active[c] && sel_hit[c] |=> O_DMA_ACT[c])
      else $error("Selected source did not activate its channel.");
    dma_clear_a: assert property (I_DMA_DONE[c] && ch_active[c] && sel_hit[c] |=>
                                  O_SRC_CLR[$past(st_ff.sel[c])])
      else $error("Served channel source was not cleared.");
  end
  claim_block_a: assert property ((O_CPU_IRQ & $past(claim_vec)) == '0)
    else $error("Claimed source reached the CPU.");
  claim_vec_a: assert property ($rose(O_XC_ACT_REQ) |->
                                (($past(claim_vec) >> O_XC_VECTOR) & IAR_NUM_SRC'(1)) == '0)
    else $error("Claimed source was sent to the controller.");
  steer_xc_a: assert property (st_ff.state == IAR_IDLE && |xc_pend |=> O_XC_ACT_REQ)
    else $error("Enabled source did not request activation.");
  steer_cpu_a: assert property (|(I_SRC_REQ & ~claim_vec & ~en_flat) |=>
                                |O_CPU_IRQ)
    else $error("Disabled source did not reach the CPU.");
  five_regs_a: assert property (I_RD && I_ADDR ==
                                reg_addr(IAR_EN_BASE_ADDR, IAR_NUM_EN_REGS) |=>
                                O_RDATA == '0)
    else $error("Address past register E returned data.");
  source_clear_disable_select_keep_a: assert property (O_XC_ACT_REQ && I_XC_DONE && I_XC_SOURCE_CLEAR_DISABLE_SELECT &&
                                 I_DMA_DONE == '0 |=> O_SRC_CLR == '0)
    else $error("Source cleared although clear was disabled.");
  hand_keep_a: assert property (O_XC_ACT_REQ && I_XC_DONE && I_XC_SOURCE_CLEAR_DISABLE_SELECT |=> ##1
                                (!O_XC_ACT_REQ || O_XC_VECTOR != $past(O_XC_VECTOR, 2)))
    else $error("Source handed to the CPU was activated again.");
  clr_done_a: assert property (O_XC_ACT_REQ && I_XC_DONE && !I_XC_SOURCE_CLEAR_DISABLE_SELECT |=>
                               O_SRC_CLR[$past(O_XC_VECTOR)] && !O_XC_ACT_REQ)
    else $error("Served source was not cleared.");
  no_retake_a: assert property ($rose(O_XC_ACT_REQ) |->
                                (($past(O_SRC_CLR) >> O_XC_VECTOR) & IAR_NUM_SRC'(1)) == '0)
    else $error("Source taken again while its clear was in flight.");
  act_hold_a: assert property (O_XC_ACT_REQ && !I_XC_DONE |=>
                               O_XC_ACT_REQ && $stable(O_XC_VECTOR))
    else $error("Activation request dropped before done.");
  valid_bits_a: assert property (I_RD && I_ADDR == IAR_EN_BASE_ADDR |=>
                                 (O_RDATA & ~SRC_VALID[IAR_EN_WIDTH-1:0]) == '0)
    else $error("Unassigned enable bit read as one.");

endmodule : iar_router

// ==== verif/iar_far_model.sv ====
`timescale 1ns/10ps
module iar_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_act_req,
  input  wire logic [3:0] i_dma_act,
  input  wire logic [3:0] i_wait,
  input  wire logic       i_source_clear_disable_select,
  output logic            o_xc_done,
  output logic            o_xc_source_clear_disable_select,
  output logic [3:0]      o_dma_done
);
  logic [3:0] cnt_ff;
  logic       held_ff;
  logic [3:0] seen_ff;
  // The clear-disable level is only meaningful beside done, so it is inverted elsewhere.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_ff     <= 4'h0;
      held_ff    <= 1'b0;
      seen_ff    <= 4'h0;
      o_xc_done  <= 1'b0;
      o_xc_source_clear_disable_select <= 1'b0;
      o_dma_done <= 4'h0;
    end else begin
      o_xc_done  <= 1'b0;
      o_xc_source_clear_disable_select <= ~i_source_clear_disable_select;
      o_dma_done <= i_dma_act & ~seen_ff;
      seen_ff    <= i_dma_act;
      if (!i_act_req) begin
        held_ff <= 1'b0;
      end else if (!held_ff) begin
        if (cnt_ff == i_wait) begin
          o_xc_done  <= 1'b1;
          o_xc_source_clear_disable_select <= i_source_clear_disable_select;
          held_ff    <= 1'b1;
          cnt_ff     <= 4'h0;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule : iar_far_model

// ==== verif/test_interrupt_activation_router.sv ====
`timescale 1ns/10ps
module test_interrupt_activation_router;
  import iar_pkg::*;
  logic                   clk, rst_b, wr, rd, source_clear_disable_select, xc_done, xc_source_clear_disable_select, act;
  logic [IAR_ADDR_W-1:0]  addr;
  logic [IAR_DATA_W-1:0]  wdata, rdata;
  logic [IAR_NUM_SRC-1:0] src, irq, clr;
  logic [3:0]             dma_done, dma_act, wt;
  logic [IAR_SEL_W-1:0]   vec;
  int                     failures, checks_done, s, c, n;
  int                     en [8];
  // Source 15 has no owner in this build, so its enable bit must read zero.
  localparam logic [IAR_NUM_SRC-1:0] VALID = {{64{1'b1}}, 16'h7fff};
  iar_router #(.SRC_VALID(VALID)) u_iar_router (.I_CLK(clk), .I_RST_B(rst_b),
    .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SRC_REQ(src), .I_DMA_DONE(dma_done),
    .O_DMA_ACT(dma_act), .I_XC_DONE(xc_done), .I_XC_SOURCE_CLEAR_DISABLE_SELECT(xc_source_clear_disable_select), .O_XC_ACT_REQ(act),
    .O_XC_VECTOR(vec), .O_CPU_IRQ(irq), .O_SRC_CLR(clr));
  iar_far_model u_iar_far_model (.i_clk(clk), .i_rst_b(rst_b), .i_act_req(act),
    .i_dma_act(dma_act), .i_wait(wt), .i_source_clear_disable_select(source_clear_disable_select), .o_xc_done(xc_done),
    .o_xc_source_clear_disable_select(xc_source_clear_disable_select), .o_dma_done(dma_done));
  task complete_run;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task chk(input logic [79:0] got, input logic [79:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [19:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(80'(rdata), 80'(e), "rdata");
  endtask : rd_chk
  // Waits are bounded so a stuck output ends the run instead of hanging it.
  task wait_for(input int w);
    n = 0;
    #1;
    while ((w == 0 ? act : w == 1 ? clr[s] : w == 2 ? irq[s] : dma_act[c]) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n == 50) begin
        failures++;
        $display("CHECK FAILED t=%0t wait %0d timed out", $time, w);
        complete_run();
      end
    end
  endtask : wait_for
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_b, wr, rd, source_clear_disable_select, addr, wdata, src, wt, failures, checks_done} = '0;
    void'($urandom(21725));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 8; k++) rd_chk(20'(IAR_EN_BASE_ADDR + k * 2), 16'h0);
    for (int k = 0; k < 8; k++) begin
      en[k] = int'($urandom_range(16'hffff));
      wr_reg(20'(IAR_EN_BASE_ADDR + k * 2), 16'(en[k]));
      en[k] = (k < 5) ? int'(16'(en[k]) & VALID[(k % 5) * 16 +: 16]) : 0;
    end
    for (int k = 0; k < 8; k++) rd_chk(20'(IAR_EN_BASE_ADDR + k * 2), 16'(en[k]));
    for (int k = 0; k < 5; k++) wr_reg(20'(IAR_EN_BASE_ADDR + k * 2), 16'h0);
    $display("test registers done");
    s = $urandom_range(79);
    @(posedge clk) src[s] <= 1'b1;
    @(posedge clk);
    #1 chk(irq, 80'h1 << s, "cpu route");
    chk(80'(act), 80'h0, "no activation");
    @(posedge clk) src <= '0;
    $display("test cpu route done");
    for (int p = 0; p < 2; p++) begin
      // Register A holds the unowned source, so this test stays above it.
      s = 16 + $urandom_range(63);
      wt <= 4'($urandom_range(5));
      source_clear_disable_select <= p[0];
      wr_reg(20'(IAR_EN_BASE_ADDR + (s / 16) * 2), 16'h1 << (s % 16));
      @(posedge clk) src[s] <= 1'b1;
      wait_for(0);
      chk(80'(vec), 80'(s), "vector");
      chk(irq, 80'h0, "held from cpu");
      wait_for(p == 0 ? 1 : 2);
      chk(p == 0 ? clr : irq, 80'h1 << s, "after done");
      @(posedge clk) src <= '0;
      wr_reg(20'(IAR_EN_BASE_ADDR + (s / 16) * 2), 16'h0);
      $display("test controller route done");
    end
    c = $urandom_range(3);
    s = $urandom_range(79);
    wr_reg(20'(IAR_CH_SEL_BASE + c * 2), 16'(s));
    wr_reg(20'(IAR_CH_MODE_BASE + c * 2), 16'hb);
    rd_chk(20'(IAR_CH_SEL_BASE + c * 2), 16'(s));
    wr_reg(20'(IAR_EN_BASE_ADDR + (s / 16) * 2), 16'h1 << (s % 16));
    @(posedge clk) src[s] <= 1'b1;
    wait_for(3);
    chk(80'(dma_act), 80'h1 << c, "dma activation");
    chk(irq | 80'(act), 80'h0, "claimed source withheld");
    wait_for(1);
    chk(clr, 80'h1 << s, "dma clear");
    @(posedge clk) src <= '0;
    $display("test dma claim done");
    wr_reg(20'(IAR_EN_BASE_ADDR + (s / 16) * 2), 16'h0);
    wr_reg(20'(IAR_CH_MODE_BASE + c * 2), 16'ha);
    @(posedge clk) src[s] <= 1'b1;
    @(posedge clk);
    #1 chk(irq, 80'h1 << s, "unclaimed to cpu");
    chk(80'(dma_act), 80'h0, "unclaimed no dma");
    @(posedge clk) src <= '0;
    $display("test unclaimed channel done");
    complete_run();
  end
endmodule : test_interrupt_activation_router
